// [rtl/ues_top.v]
// command port, cause register, endpoint status and buffer reads
`timescale 1ns/1ps
`include "ues_defines.vh"
module ues_top #(
    parameter EP_NUM = 6,
    parameter PTR_W  = 8
) (
    input  wire                     i_clk,
    input  wire                     i_sys_rst,
    // microcontroller pins
    input  wire                     i_a0,
    input  wire                     i_wr_n,
    input  wire                     i_rd_n,
    input  wire [7:0]               i_data,
    output reg  [7:0]               o_data,
    output reg                      o_data_oe,
    output reg                      o_int_n,
    // serial engine side
    input  wire                     i_usb_bus_rst,
    input  wire                     i_sof,
    input  wire                     i_frame_tick,
    input  wire                     i_ev_valid,
    input  wire [2:0]               i_ev_ep,
    input  wire                     i_ev_ok,
    input  wire [3:0]               i_ev_err,
    input  wire                     i_ev_setup,
    input  wire                     i_ev_data1,
    input  wire [EP_NUM-1:0]        i_ep_full,
    input  wire [EP_NUM-1:0]        i_ep_stall,
    input  wire                     i_buf_we,
    input  wire [PTR_W+2:0]         i_buf_waddr,
    input  wire [7:0]               i_buf_wdata,
    // configuration bits held elsewhere
    input  wire                     i_sof_only,
    input  wire                     i_pin_mode,
    input  wire                     i_addr_load,
    input  wire [6:0]               i_addr_val,
    // dma read side
    input  wire                     i_dma_rd,
    input  wire                     i_dma_done,
    output reg  [7:0]               o_dma_data,
    output reg                      o_dma_valid,
    // function state
    output reg                      o_func_enable,
    output reg  [6:0]               o_func_addr,
    output reg                      o_suspend
);
    localparam ST_IDLE  = 2'b01;
    localparam ST_FETCH = 2'b10;
    reg  [10:0]           pin_s1_reg;
    reg  [10:0]           pin_s2_reg;
    reg                   wr_n_prev_reg, rd_n_prev_reg, int_idx_reg;
    reg  [7:0]            cmd_reg;
    reg  [2:0]            sel_ep_reg;
    reg  [PTR_W-1:0]      ptr_reg;
    reg  [PTR_W-1:0]      dma_ptr_reg;
    reg                   dma_pend_reg, dma_fetch_reg;
    reg  [1:0]            state_reg;
    reg                   bus_rst_flag_reg, susp_chg_reg;
    reg                   dma_flag_reg, sof_flag_reg;
    reg  [1:0]            miss_cnt_reg;
    wire                  s_a0, s_wr_n, s_rd_n, cmd_wr, data_rd;
    wire [7:0]            s_din;
    wire                  is_sel, is_lts, is_buf, susp_set;
    wire [2:0]            cmd_ep;
    wire [8*EP_NUM-1:0]   st_all;
    wire [EP_NUM-1:0]     pend_all;
    wire [EP_NUM-1:0]     lts_clr;
    wire [7:0]            int_low;
    wire [7:0]            int_high;
    wire                  int_low_rd, int_high_rd, buf_rd;
    wire                  dma_go, mem_re, normal_int;
    wire [PTR_W+2:0]      mem_raddr;
    wire [7:0]            mem_rdata;
    reg                   int_act;
    reg  [7:0]            reply;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_s1_reg    <= 11'h600;
            pin_s2_reg    <= 11'h600;
            wr_n_prev_reg <= 1'b1;
            rd_n_prev_reg <= 1'b1;
        end else begin
            pin_s1_reg    <= {i_wr_n, i_rd_n, i_a0, i_data};
            pin_s2_reg    <= pin_s1_reg;
            wr_n_prev_reg <= s_wr_n;
            rd_n_prev_reg <= s_rd_n;
        end
    end

    assign s_wr_n  = pin_s2_reg[10];
    assign s_rd_n  = pin_s2_reg[9];
    assign s_a0    = pin_s2_reg[8];
    assign s_din   = pin_s2_reg[7:0];
    // command taken at write rising edge, data read at read fall
    assign cmd_wr  = s_wr_n & ~wr_n_prev_reg & s_a0;
    assign data_rd = ~s_rd_n & rd_n_prev_reg & ~s_a0;

    ////////////////////////////////////////////////////////////////////
    // command decode
    assign is_sel = (cmd_reg >= `UES_CMD_SEL_FIRST) &&
                    (cmd_reg <= `UES_CMD_SEL_LAST);
    assign is_lts = (cmd_reg >= `UES_CMD_LTS_FIRST) &&
                    (cmd_reg <= `UES_CMD_LTS_LAST);
    assign is_buf = (cmd_reg == `UES_CMD_RD_BUF);
    assign cmd_ep = cmd_reg[2:0];

    assign int_low_rd  = data_rd && (cmd_reg == `UES_CMD_RD_INT) &&
                         !int_idx_reg;
    assign int_high_rd = data_rd && (cmd_reg == `UES_CMD_RD_INT) &&
                         int_idx_reg;
    assign buf_rd      = data_rd && is_buf &&
                         (ptr_reg < `UES_BUF_MAX_RD);

    // command register, endpoint select and read byte index
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cmd_reg     <= 8'hff;
            int_idx_reg <= 1'b0;
            sel_ep_reg  <= 3'h0;
        end else if (i_usb_bus_rst) begin
            cmd_reg     <= 8'hff;
            int_idx_reg <= 1'b0;
            sel_ep_reg  <= 3'h0;
        end else if (cmd_wr) begin
            cmd_reg     <= s_din;
            int_idx_reg <= 1'b0;
            if ((s_din >= `UES_CMD_SEL_FIRST) &&
                (s_din <= `UES_CMD_SEL_LAST)) begin
                sel_ep_reg <= s_din[2:0];
            end
        end else if (int_low_rd) begin
            int_idx_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per endpoint last status holders
    genvar gi;
    generate
        for (gi = 0; gi < EP_NUM; gi = gi + 1) begin : g_ep
            assign lts_clr[gi] = data_rd && is_lts &&
                                 (cmd_ep == gi);
            ues_ep_status #(
                .IS_IN  (gi % 2)
            ) u_status (
                .i_clk     (i_clk),
                .i_sys_rst (i_sys_rst),
                .i_bus_rst (i_usb_bus_rst),
                .i_ev      (i_ev_valid && (i_ev_ep == gi)),
                .i_ok      (i_ev_ok),
                .i_err     (i_ev_err),
                .i_setup   (i_ev_setup),
                .i_data1   (i_ev_data1),
                .i_clr     (lts_clr[gi]),
                .o_status  (st_all[8*gi+7:8*gi]),
                .o_pend    (pend_all[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // cause bits other than endpoints; a set beats a clear
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bus_rst_flag_reg <= 1'b0;
            susp_chg_reg     <= 1'b0;
            dma_flag_reg     <= 1'b0;
            sof_flag_reg     <= 1'b0;
        end else if (i_usb_bus_rst) begin
            bus_rst_flag_reg <= 1'b1;
            susp_chg_reg     <= 1'b0;
            dma_flag_reg     <= 1'b0;
            sof_flag_reg     <= 1'b0;
        end else begin
            if (int_low_rd) begin
                bus_rst_flag_reg <= 1'b0;
            end
            if (susp_set) begin
                susp_chg_reg <= 1'b1;
            end else if (int_low_rd) begin
                susp_chg_reg <= 1'b0;
            end
            if (i_dma_done) begin
                dma_flag_reg <= 1'b1;
            end else if (int_high_rd) begin
                dma_flag_reg <= 1'b0;
            end
            if (i_sof) begin
                sof_flag_reg <= 1'b1;
            end else if (int_low_rd) begin
                sof_flag_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // suspend detection from missed start-of-frame ticks
    assign susp_set = (i_sof && o_suspend) ||
                      (i_frame_tick && !i_sof && !o_suspend &&
                       (miss_cnt_reg == `UES_SOF_MISS_MAX - 2'h1));
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            miss_cnt_reg <= 2'h0;
            o_suspend    <= 1'b0;
        end else if (i_usb_bus_rst) begin
            miss_cnt_reg <= 2'h0;
            o_suspend    <= 1'b0;
        end else if (i_sof) begin
            miss_cnt_reg <= 2'h0;
            o_suspend    <= 1'b0;
        end else if (i_frame_tick &&
                     miss_cnt_reg != `UES_SOF_MISS_MAX) begin
            miss_cnt_reg <= miss_cnt_reg + 2'h1;
            if (miss_cnt_reg == `UES_SOF_MISS_MAX - 2'h1) begin
                o_suspend <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // function enable and address
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_func_enable <= 1'b0;
            o_func_addr   <= 7'h00;
        end else if (i_usb_bus_rst) begin
            o_func_enable <= 1'b1;
            o_func_addr   <= 7'h00;
        end else if (i_addr_load) begin
            o_func_addr   <= i_addr_val;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // buffer memory and its read arbitration
    assign dma_go    = dma_pend_reg && (state_reg == ST_IDLE) &&
                       !buf_rd;
    assign mem_re    = buf_rd || dma_go;
    assign mem_raddr = buf_rd ? {sel_ep_reg, ptr_reg}
                              : {`UES_DMA_EP, dma_ptr_reg};

    ues_buf_mem #(
        .AW (PTR_W + 3),
        .DW (8)
    ) u_mem (
        .i_clk   (i_clk),
        .i_we    (i_buf_we),
        .i_waddr (i_buf_waddr),
        .i_wdata (i_buf_wdata),
        .i_re    (mem_re),
        .i_raddr (mem_raddr),
        .o_rdata (mem_rdata)
    );

    // microcontroller buffer pointer
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ptr_reg <= {PTR_W{1'b0}};
        end else if (i_usb_bus_rst) begin
            ptr_reg <= {PTR_W{1'b0}};
        end else if (cmd_wr && (s_din <= `UES_CMD_SEL_LAST)) begin
            ptr_reg <= {PTR_W{1'b0}};
        end else if (buf_rd) begin
            ptr_reg <= ptr_reg + 1'b1;
        end
    end

    // dma reads start past the reserved and count bytes
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dma_ptr_reg   <= `UES_DMA_HDR_SKIP;
            dma_pend_reg  <= 1'b0;
            dma_fetch_reg <= 1'b0;
            o_dma_data    <= 8'h00;
            o_dma_valid   <= 1'b0;
        end else if (i_usb_bus_rst || i_dma_done) begin
            dma_ptr_reg   <= `UES_DMA_HDR_SKIP;
            dma_pend_reg  <= 1'b0;
            dma_fetch_reg <= 1'b0;
            o_dma_valid   <= 1'b0;
        end else begin
            if (dma_go) begin
                dma_ptr_reg  <= dma_ptr_reg + 1'b1;
                dma_pend_reg <= i_dma_rd;
            end else if (i_dma_rd) begin
                dma_pend_reg <= 1'b1;
            end
            dma_fetch_reg <= dma_go;
            o_dma_valid   <= dma_fetch_reg;
            if (dma_fetch_reg) begin
                o_dma_data <= mem_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reply byte for non-buffer reads
    assign int_low  = {susp_chg_reg, bus_rst_flag_reg, pend_all};
    assign int_high = {7'h00, dma_flag_reg};

    integer k;
    always @* begin
        reply = 8'h00;
        if (cmd_reg == `UES_CMD_RD_INT) begin
            reply = int_idx_reg ? int_high : int_low;
        end else if (is_sel) begin
            reply[`UES_SEL_FULL]  = i_ep_full[cmd_ep];
            reply[`UES_SEL_STALL] = i_ep_stall[cmd_ep];
        end else if (is_lts) begin
            for (k = 0; k < EP_NUM; k = k + 1) begin
                if (cmd_ep == k) begin
                    reply = st_all[8*k +: 8];
                end
            end
        end
    end

    // read sequencer and data bus drive
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            o_data    <= 8'h00;
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= ~s_rd_n & ~s_a0;
            case (state_reg)
                ST_IDLE: begin
                    if (buf_rd) begin
                        state_reg <= ST_FETCH;
                    end else if (data_rd) begin
                        o_data <= reply;
                    end
                end
                ST_FETCH: begin
                    o_data    <= mem_rdata;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt pin source selection
    assign normal_int = |int_low | |int_high;
    always @* begin
        if (i_sof_only) begin
            int_act = sof_flag_reg;
        end else if (i_pin_mode) begin
            int_act = normal_int | sof_flag_reg;
        end else begin
            int_act = normal_int;
        end
    end

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_int_n <= 1'b1;
        end else begin
            o_int_n <= ~int_act;
        end
    end
endmodule

// [rtl/ues_defines.vh]
// constants for the endpoint status and buffer read block
`ifndef UES_DEFINES_VH
`define UES_DEFINES_VH
// command codes
`define UES_CMD_SEL_FIRST  8'h00
`define UES_CMD_SEL_LAST   8'h05
`define UES_CMD_LTS_FIRST  8'h40
`define UES_CMD_LTS_LAST   8'h45
`define UES_CMD_RD_BUF     8'hf0
`define UES_CMD_RD_INT     8'hf4
// cause register bit positions
`define UES_INT_BUS_RST    6
`define UES_INT_SUSP_CHG   7
`define UES_INT_DMA_DONE   0
// last status fields
`define UES_LTS_OK         0
`define UES_LTS_ERR_LSB    1
`define UES_LTS_SETUP      5
`define UES_LTS_DATA1      6
`define UES_LTS_UNREAD     7
// select endpoint status fields
`define UES_SEL_FULL       0
`define UES_SEL_STALL      1
// error codes driven in by the serial engine
`define UES_ERR_NONE       4'h0
`define UES_ERR_PID_ENC    4'h1
`define UES_ERR_PID_UNK    4'h2
`define UES_ERR_UNEXP      4'h3
`define UES_ERR_TOK_CRC    4'h4
`define UES_ERR_DAT_CRC    4'h5
`define UES_ERR_TIMEOUT    4'h6
`define UES_ERR_UNEXP_EOP  4'h8
`define UES_ERR_NAK        4'h9
`define UES_ERR_STALL      4'ha
`define UES_ERR_OVERFLOW   4'hb
`define UES_ERR_BITSTUFF   4'hd
`define UES_ERR_WRONG_PID  4'hf
// counts
`define UES_SOF_MISS_MAX   2'h3
`define UES_BUF_MAX_RD     8'h82
`define UES_DMA_HDR_SKIP   8'h02
`define UES_DMA_EP         3'h4
`endif

// [rtl/ues_buf_mem.v]
// endpoint buffer memory with registered read data
`timescale 1ns/1ps
module ues_buf_mem #(
    parameter AW = 11,
    parameter DW = 8
) (
    input  wire          i_clk,
    input  wire          i_we,
    input  wire [AW-1:0] i_waddr,
    input  wire [DW-1:0] i_wdata,
    input  wire          i_re,
    input  wire [AW-1:0] i_raddr,
    output reg  [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // write port from the serial engine
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // read port, data one cycle after the request
    always @(posedge i_clk) begin
        if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// [rtl/ues_ep_status.v]
// last transaction status holder for one endpoint
`timescale 1ns/1ps
`include "ues_defines.vh"
module ues_ep_status #(
    parameter IS_IN = 1'b0
) (
    input  wire       i_clk,
    input  wire       i_sys_rst,
    input  wire       i_bus_rst,
    input  wire       i_ev,
    input  wire       i_ok,
    input  wire [3:0] i_err,
    input  wire       i_setup,
    input  wire       i_data1,
    input  wire       i_clr,
    output reg  [7:0] o_status,
    output reg        o_pend
);
    // capture or consume status; new event wins over clear
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_status <= 8'h00;
            o_pend   <= 1'b0;
        end else if (i_bus_rst) begin
            o_status <= 8'h00;
            o_pend   <= 1'b0;
        end else if (i_ev) begin
            o_status[`UES_LTS_OK] <= i_ok;
            o_status[`UES_LTS_ERR_LSB+3:`UES_LTS_ERR_LSB] <= i_err;
            o_status[`UES_LTS_SETUP] <= i_ok & i_setup & (IS_IN == 0);
            o_status[`UES_LTS_DATA1] <= i_data1;
            o_status[`UES_LTS_UNREAD] <= o_pend & ~i_clr;
            o_pend <= 1'b1;
        end else if (i_clr) begin
            o_status <= 8'h00;
            o_pend   <= 1'b0;
        end
    end
endmodule

// [testbench/ues_top_monitor.sv]
// concurrent checks on cause, suspend and dma outputs of the block
`timescale 1ns/1ps
module ues_top_monitor (
    input wire       i_clk,
    input wire       i_sys_rst,
    input wire       i_usb_bus_rst,
    input wire       i_sof,
    input wire       i_frame_tick,
    input wire       i_ev_valid,
    input wire       i_sof_only,
    input wire       i_pin_mode,
    input wire       i_dma_rd,
    input wire       i_dma_done,
    input wire       o_int_n,
    input wire       o_dma_valid,
    input wire       o_func_enable,
    input wire [6:0] o_func_addr,
    input wire       o_suspend
);
    reg [1:0] miss_reg;
    // frame ticks since the last sof, saturating at three
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            miss_reg <= 2'h0;
        else if (i_sof || i_usb_bus_rst)
            miss_reg <= 2'h0;
        else if (i_frame_tick && miss_reg != 2'h3)
            miss_reg <= miss_reg + 2'h1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // interrupt pin pulled low shortly after a cause
    sequence s_irq;
        ##[1:3] !o_int_n;
    endsequence
    // function enabled at the default address
    sequence s_up;
        ##[1:2] o_func_enable && o_func_addr == 7'h00;
    endsequence
    a_bus_rst_up: assert property (i_usb_bus_rst |-> s_up)
        else $error("bus reset did not enable at address zero");
    a_bus_rst_irq: assert property (
        i_usb_bus_rst && !i_sof_only |-> s_irq)
        else $error("bus reset raised no interrupt");
    a_ev_irq: assert property (i_ev_valid && !i_sof_only |-> s_irq)
        else $error("endpoint event raised no interrupt");
    a_sof_pin_irq: assert property (
        i_sof && i_pin_mode && !i_sof_only |-> s_irq)
        else $error("sof missing from interrupt in pin mode");
    a_sof_only_irq: assert property (i_sof && i_sof_only |-> s_irq)
        else $error("sof missing from interrupt in sof only mode");
    a_susp_count: assert property ($rose(o_suspend) |-> miss_reg == 2'h3)
        else $error("suspend entered without three missed frames");
    a_susp_irq: assert property (
        $changed(o_suspend) && !i_sof_only |-> ##[0:3] !o_int_n)
        else $error("suspend change raised no interrupt");
    a_sof_wake: assert property (o_suspend && i_sof |-> ##[1:2] !o_suspend)
        else $error("sof did not wake the function");
    a_dma_serve: assert property (i_dma_rd |-> ##[1:6] o_dma_valid)
        else $error("dma byte request not served");
    a_dma_done_irq: assert property (
        i_dma_done && !i_sof_only |-> s_irq)
        else $error("dma completion raised no interrupt");
endmodule
bind ues_top ues_top_monitor i_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_usb_bus_rst(i_usb_bus_rst), .i_sof(i_sof), .i_frame_tick(i_frame_tick),
    .i_ev_valid(i_ev_valid), .i_sof_only(i_sof_only), .i_pin_mode(i_pin_mode),
    .i_dma_rd(i_dma_rd), .i_dma_done(i_dma_done), .o_int_n(o_int_n),
    .o_dma_valid(o_dma_valid), .o_func_enable(o_func_enable),
    .o_func_addr(o_func_addr), .o_suspend(o_suspend));

// [testbench/ues_mcu_model.sv]
// microcontroller model on the parallel command port
`timescale 1ns/1ps
module ues_mcu_model (
    input  wire       i_clk,
    input  wire [7:0] i_rdata,
    output reg        o_a0,
    output reg        o_wr_n,
    output reg        o_rd_n,
    output reg  [7:0] o_wdata,
    output reg  [7:0] o_rd_byte,
    output reg        o_rd_done
);
    // idle pins at time zero
    initial begin
        o_a0 = 1'h1;
        o_wr_n = 1'h1;
        o_rd_n = 1'h1;
        o_wdata = 8'h00;
        o_rd_byte = 8'h00;
        o_rd_done = 1'h0;
    end
    // wait falling edges
    task gap(input integer n);
        repeat (n) @(negedge i_clk);
    endtask
    // command write, held well past the synchroniser
    task cmd(input [7:0] c);
        o_a0 = 1'h1;
        o_wdata = c;
        o_wr_n = 1'h0;
        gap(5);
        o_wr_n = 1'h1;
        gap(2);
        o_wdata = ~c; // released bus shows no stale code
        gap(3);
    endtask
    // data read, sampled just before the strobe is released
    task rd;
        o_a0 = 1'h0;
        o_rd_n = 1'h0;
        gap(6);
        o_rd_byte = i_rdata;
        o_rd_done = 1'h1;
        gap(1);
        o_rd_done = 1'h0;
        o_rd_n = 1'h1;
        gap(5);
    endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the status and buffer read block
`timescale 1ns/1ps
`include "ues_defines.vh"
module tb_top;
    reg          i_clk = 1'h0;
    reg          i_sys_rst = 1'h1;
    wire         i_a0, i_wr_n, i_rd_n, o_data_oe, o_int_n, o_dma_valid;
    wire         o_func_enable, o_suspend, rd_done;
    wire  [7:0]  i_data, o_data, o_dma_data, rd_byte;
    wire  [6:0]  o_func_addr;
    reg   [5:0]  pls = 6'h00;
    wire         i_usb_bus_rst = pls[0], i_sof = pls[1], i_frame_tick = pls[2];
    wire         i_dma_rd = pls[3], i_dma_done = pls[4], i_addr_load = pls[5];
    reg          i_ev_valid = 1'h0, i_ev_ok = 1'h0, i_ev_setup = 1'h0;
    reg          i_ev_data1 = 1'h0, i_buf_we = 1'h0, i_sof_only = 1'h0;
    reg          i_pin_mode = 1'h0, sc = 1'h0, br = 1'h0;
    reg   [2:0]  i_ev_ep = 3'h0;
    reg   [3:0]  i_ev_err = 4'h0;
    reg   [5:0]  i_ep_full = 6'h00, i_ep_stall = 6'h00, pend = 6'h00;
    reg   [10:0] i_buf_waddr = 11'h000;
    reg   [7:0]  i_buf_wdata = 8'h00, mm [0:2047], st [0:5], rq[$], dq[$];
    reg   [6:0]  i_addr_val = 7'h00;
    reg   [31:0] seed = 32'h35;
    reg   [51:0] codes = 52'h012345689abdf;
    integer      err_total = 0, samples_checked = 0, k;
    ues_top i_ues_top (.*);
    ues_mcu_model i_ues_mcu_model (.i_clk(i_clk), .i_rdata(o_data),
        .o_a0(i_a0), .o_wr_n(i_wr_n), .o_rd_n(i_rd_n), .o_wdata(i_data),
        .o_rd_byte(rd_byte), .o_rd_done(rd_done));
    always #20 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////
    function logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task chk(input [7:0] seen, input [7:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: seen %h wanted %h", $time, seen, exp);
        end
    endtask
    task chb(input b, input e);
        chk({7'h00, b}, {7'h00, e});
    endtask
    task complete_run;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge i_clk);
    endtask
    task pulse(input integer b);
        pls[b] = 1'h1;
        cyc(1);
        pls[b] = 1'h0;
        cyc(3);
    endtask
    task cmd(input [7:0] c);
        i_ues_mcu_model.cmd(c);
    endtask
    task rd(input [7:0] e);
        rq.push_back(e);
        i_ues_mcu_model.rd;
    endtask
    // one finished transaction, expected status noted alongside
    task ev(input [2:0] e, input [3:0] c, input s, input d);
        i_ev_ep = e;
        i_ev_err = c;
        i_ev_ok = (c == 4'h0);
        i_ev_setup = s;
        i_ev_data1 = d & i_ev_ok;
        st[e] = {pend[e], i_ev_data1, s & i_ev_ok & ~e[0], c, i_ev_ok};
        pend[e] = 1'h1;
        i_ev_valid = 1'h1;
        cyc(1);
        i_ev_valid = 1'h0;
        cyc(4);
    endtask
    task lts(input [2:0] e);
        cmd({5'h08, e});
        rd(st[e]);
        st[e] = 8'h00;
        pend[e] = 1'h0;
    endtask
    task icr(input [7:0] hi);
        cmd(`UES_CMD_RD_INT);
        rd({sc, br, pend});
        rd(hi);
        sc = 1'h0;
        br = 1'h0;
    endtask
    task fill(input [2:0] e);
        for (k = 0; k < 132; k = k + 1) begin
            i_buf_we = 1'h1;
            i_buf_waddr = {e, k[7:0]};
            i_buf_wdata = rnd();
            mm[{e, k[7:0]}] = i_buf_wdata;
            cyc(1);
        end
        i_buf_we = 1'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // compare every finished read against the oldest note
    always @(posedge i_clk) begin
        if (rd_done) begin
            chk(rd_byte, rq.size() ? rq.pop_front() : 8'hxx);
            chb(o_data_oe, 1'h1);
        end
        if (o_dma_valid)
            chk(o_dma_data, dq.size() ? dq.pop_front() : 8'hxx);
    end
    // watchdog against a hung handshake
    initial begin
        #800000;
        err_total = err_total + 1;
        complete_run;
    end
    // main sequence
    initial begin
        cyc(4);
        i_sys_rst = 1'h0;
        chb(o_int_n, 1'h1);
        chb(o_data_oe, 1'h0);
        i_addr_val = rnd();
        pulse(5);
        pulse(0);
        br = 1'h1;
        chb(o_func_enable, 1'h1);
        chk({1'h0, o_func_addr}, 8'h00);
        chb(o_int_n, 1'h0);
        icr(8'h00);
        icr(8'h00);
        for (k = 0; k < 13; k = k + 1) begin
            ev(3'h2, codes[k*4 +: 4], k[0], k[1]);
            if (k[2])
                ev(3'h2, codes[k*4 +: 4], 1'h1, 1'h1);
            lts(3'h2);
        end
        for (k = 0; k < 6; k = k + 1)
            ev(k[2:0], 4'h0, 1'h1, k[1]);
        icr(8'h00);
        icr(8'h00);
        for (k = 0; k < 6; k = k + 1)
            lts(k[2:0]);
        icr(8'h00);
        chb(o_int_n, 1'h1);
        fill(3'h4);
        for (k = 0; k < 3; k = k + 1) begin
            dq.push_back(mm[1026+k]);
            pulse(3);
        end
        pulse(4);
        icr(8'h01);
        icr(8'h00);
        dq.push_back(mm[1026]);
        pulse(3);
        i_ep_full = rnd();
        i_ep_stall = rnd();
        fill(3'h5);
        for (k = 0; k < 6; k = k + 1) begin
            cmd({5'h00, k[2:0]});
            rd({6'h00, i_ep_stall[k], i_ep_full[k]});
        end
        cmd(`UES_CMD_RD_BUF);
        for (k = 0; k < 130; k = k + 1) begin
            if (k == 3) begin
                icr(8'h00);
                cmd(`UES_CMD_RD_BUF);
            end
            rd(mm[1280+k]);
        end
        rd(8'h00);
        cmd(8'h05);
        cmd(`UES_CMD_RD_BUF);
        rd(mm[1280]);
        for (k = 0; k < 3; k = k + 1) begin
            chb(o_suspend, 1'h0);
            pulse(2);
        end
        chb(o_suspend, 1'h1);
        sc = 1'h1;
        icr(8'h00);
        pulse(1);
        chb(o_suspend, 1'h0);
        sc = 1'h1;
        icr(8'h00);
        pulse(1);
        chb(o_int_n, 1'h1);
        i_pin_mode = 1'h1;
        cyc(3);
        chb(o_int_n, 1'h0);
        pulse(1);
        icr(8'h00);
        chb(o_int_n, 1'h1);
        ev(3'h3, 4'h0, 1'h0, 1'h1);
        i_pin_mode = 1'h0;
        i_sof_only = 1'h1;
        cyc(3);
        chb(o_int_n, 1'h1);
        pulse(1);
        chb(o_int_n, 1'h0);
        icr(8'h00);
        i_sof_only = 1'h0;
        cyc(3);
        chb(o_int_n, 1'h0);
        lts(3'h3);
        cyc(3);
        chb(o_int_n, 1'h1);
        complete_run;
    end
endmodule
